// file: adcrtc_pkg.sv
// Constants and carrier types for the converter result and trigger control block.
// Assumes a byte-wide register map reached over a 32-bit APB slave, one word per register.
package adcrtc_pkg;

  // ==========================================================================
  // Register indices (byte address is four times the index)
  localparam logic [9:0] IDX_ANALOG_MISC    = 10'h077;
  localparam logic [9:0] IDX_RESULT_LOW     = 10'h078;
  localparam logic [9:0] IDX_RESULT_HIGH    = 10'h079;
  localparam logic [9:0] IDX_CONTROL_A      = 10'h07A;
  localparam logic [9:0] IDX_CONTROL_B      = 10'h07B;
  localparam logic [9:0] IDX_CHANNEL_SELECT = 10'h07C;
  localparam logic [9:0] IDX_DID_LOW        = 10'h07E;
  localparam logic [9:0] IDX_DID_HIGH       = 10'h07F;

  // ==========================================================================
  // Field positions
  localparam int CTLA_ENABLE_BIT   = 7;
  localparam int CTLA_AUTO_BIT     = 5;
  localparam int CTLA_DONE_BIT     = 4;
  localparam int CTLB_BIPOLAR_BIT  = 7;
  localparam int CTLB_TRIG_LSB     = 0;
  localparam int CHSEL_LEFT_BIT    = 5;
  localparam int MISC_EXT_REF_BIT  = 2;
  localparam int MISC_REF_OUT_BIT  = 1;
  localparam int MISC_ISRC_BIT     = 0;
  localparam int DIDH_LSB          = 4;

  // ==========================================================================
  // Writable-bit masks; reserved bits stay zero
  localparam logic [7:0] CTLB_WMASK  = 8'hF7;
  localparam logic [7:0] CTLA_WMASK  = 8'hA0;
  localparam logic [7:0] CHSEL_WMASK = 8'h20;
  localparam logic [7:0] DIDH_WMASK  = 8'h70;
  localparam logic [7:0] MISC_WMASK  = 8'h07;

  // ==========================================================================
  // Reset values
  localparam logic [7:0] REG_RESET    = 8'h00;
  localparam logic [9:0] RESULT_RESET = 10'h000;
  localparam logic [9:0] RESULT_FULL  = 10'h3FF;

  // ==========================================================================
  // Trigger source codes
  typedef enum logic [2:0] {
    TRIG_FREE_RUN    = 3'h0,
    TRIG_COMPARATOR  = 3'h1,
    TRIG_EXT_INT0    = 3'h2,
    TRIG_T1_CMP_A    = 3'h3,
    TRIG_T1_OVERFLOW = 3'h4,
    TRIG_T1_CMP_B    = 3'h5,
    TRIG_T1_CAPTURE  = 3'h6,
    TRIG_WATCHDOG    = 3'h7
  } adcrtc_trig_type;

  // ==========================================================================
  // Carriers
  typedef struct packed {
    logic       done;
    logic       negative;
    logic [9:0] magnitude;
  } adcrtc_conv_type;

  typedef struct packed {
    logic        psel;
    logic        penable;
    logic        pwrite;
    logic [11:0] paddr;
    logic [31:0] pwdata;
    logic [3:0]  pstrb;
  } adcrtc_apb_req_type;

  typedef struct packed {
    logic        pready;
    logic [31:0] prdata;
    logic        pslverr;
  } adcrtc_apb_rsp_type;

endpackage : adcrtc_pkg

// file: adcrtc_top.sv
// Converter result register, trigger selection and analog pin control.
// Assumes the analog core, trigger flags and APB master all run on CLOCK.
// What this block does
// - Each finished conversion loads the 10-bit result unless the result is locked; both result bytes reset to zero.
// - Reading the low byte freezes the result until the high byte is read.
// - Right adjust: high byte holds bits 9:8 low, low byte holds bits 7:0.
// - Left adjust: high byte holds bits 9:2, low byte holds bits 1:0 on top.
// - Bipolar select clear gives unipolar mode; negative input difference saturates to full scale.
// - Unipolar gives 10-bit unsigned; bipolar gives two's complement, 9 bits plus sign.
// - Control B bit 3 reads zero; software writes zero there.
// - Trigger source field acts only while auto-triggering is enabled.
// - Auto mode starts a conversion on a rising edge of the selected flag.
// - Switching from a clear source to a set source counts as a rising edge.
// - Switching to free running never yields a trigger event.
// - Source codes: free run, comparator, int0, cmp A, overflow, cmp B, capture, watchdog.
// - Pin buffer-off bits for pins 0..10 disable the buffer and force input zero.
// - Disable-high bit 7 and bits 3:0 read zero; software writes zero.
// - Analog misc bits 7:3 read zero; software writes zero.
// - External reference enable takes the reference from the external pin.
// - Reference output enable drives the internal reference onto the output pin.
// - Auto-trigger enable starts conversions on a positive edge of the selected trigger.
// - Done flag sets on result update; cleared by writing one or by vector taken.
`timescale 1ns/10ps
module adcrtc_top
  import adcrtc_pkg::*;
#(
  parameter int NUM_PINS = 11
) (
  // Clock and reset
  input  wire logic                      CLOCK,
  input  wire logic                      ARST_N,
  // APB slave
  input  wire adcrtc_pkg::adcrtc_apb_req_type APB_REQ,
  output      adcrtc_pkg::adcrtc_apb_rsp_type APB_RSP,
  // Analog core
  input  wire adcrtc_pkg::adcrtc_conv_type    CONV_IN,
  output      logic                      CONV_START,
  output      logic                      CONV_ENABLE,
  output      logic                      BIPOLAR_MODE,
  // Trigger sources, flags 1..7
  input  wire logic [7:1]                TRIG_FLAGS,
  input  wire logic                      VECTOR_TAKEN,
  output      logic                      DONE_FLAG,
  // Analog pins
  input  wire logic [NUM_PINS-1:0]       PIN_RAW,
  output      logic [NUM_PINS-1:0]       PIN_VALUE,
  output      logic [NUM_PINS-1:0]       PIN_BUFFER_OFF,
  // Reference control
  output      logic                      EXT_REF_SELECT,
  output      logic                      REF_OUT_ENABLE,
  output      logic                      ISRC_ENABLE
);

  // ==========================================================================
  // Register state
  logic [7:0]          ctla_q;
  logic [7:0]          ctlb_q;
  logic [7:0]          chsel_q;
  logic [7:0]          didl_q;
  logic [7:0]          didh_q;
  logic [7:0]          misc_q;
  logic                done_q;
  logic                lock_q;
  logic [9:0]          result_q;
  logic                pready_q;
  logic [31:0]         prdata_q;
  logic                pslverr_q;
  logic                trig_prev_q;
  logic [2:0]          src_prev_q;
  logic                start_q;
  logic [NUM_PINS-1:0] sync1_q;
  logic [NUM_PINS-1:0] sync2_q;
  logic [NUM_PINS-1:0] sync3_q;
  logic [NUM_PINS-1:0] pin_stable_q;
  logic [NUM_PINS-1:0] pin_value_q;

  // ==========================================================================
  // Functions
  function automatic logic [9:0] format_result(input logic bipolar, input logic negative,
                                               input logic [9:0] magnitude);
    logic [9:0] mag9;
    mag9 = {1'b0, magnitude[8:0]};
    if (!bipolar) begin
      format_result = negative ? RESULT_FULL : magnitude;
    end else begin
      format_result = negative ? 10'(~mag9 + 10'h001) : mag9;
    end
  endfunction : format_result

  function automatic logic [7:0] result_byte(input logic [9:0] res, input logic left,
                                             input logic high);
    if (left) begin
      result_byte = high ? res[9:2] : {res[1:0], 6'h00};
    end else begin
      result_byte = high ? {6'h00, res[9:8]} : res[7:0];
    end
  endfunction : result_byte

  function automatic logic [7:0] merge_byte(input logic [7:0] old, input logic [7:0] wdata,
                                            input logic [7:0] wmask);
    merge_byte = (wdata & wmask) | (old & ~wmask);
  endfunction : merge_byte

  // ==========================================================================
  // Bus decode
  logic [9:0] idx;
  logic       setup;
  logic       access;
  logic       wr_en;
  logic       rd_done;
  logic [7:0] wbyte;
  logic       mapped;
  logic [7:0] rbyte;

  assign idx     = APB_REQ.paddr[11:2];
  assign setup   = APB_REQ.psel && !APB_REQ.penable;
  assign access  = APB_REQ.psel && APB_REQ.penable && pready_q;
  assign wr_en   = access && APB_REQ.pwrite && APB_REQ.pstrb[0] && !pslverr_q;
  assign rd_done = access && !APB_REQ.pwrite && !pslverr_q;
  assign wbyte   = APB_REQ.pwdata[7:0];

  always_comb begin
    mapped = 1'b1;
    case (idx)
      IDX_ANALOG_MISC:    rbyte = misc_q;
      IDX_RESULT_LOW:     rbyte = result_byte(result_q, chsel_q[CHSEL_LEFT_BIT], 1'b0);
      IDX_RESULT_HIGH:    rbyte = result_byte(result_q, chsel_q[CHSEL_LEFT_BIT], 1'b1);
      IDX_CONTROL_A:      rbyte = ctla_q | ({7'h00, done_q} << CTLA_DONE_BIT);
      IDX_CONTROL_B:      rbyte = ctlb_q;
      IDX_CHANNEL_SELECT: rbyte = chsel_q;
      IDX_DID_LOW:        rbyte = didl_q;
      IDX_DID_HIGH:       rbyte = didh_q;
      default: begin
        rbyte  = 8'h00;
        mapped = 1'b0;
      end
    endcase
    if (APB_REQ.paddr[1:0] != 2'h0) begin
      mapped = 1'b0;
    end
  end

  // Answer is prepared in the setup cycle so pready can come from a flip-flop
  always_ff @(posedge CLOCK or negedge ARST_N) begin
    if (!ARST_N) begin
      pready_q  <= 1'b0;
      prdata_q  <= 32'h0000_0000;
      pslverr_q <= 1'b0;
    end else begin
      pready_q  <= setup;
      if (setup) begin
        prdata_q  <= {24'h00_0000, rbyte};
        pslverr_q <= !mapped;
      end else if (access) begin
        prdata_q  <= 32'h0000_0000;
        pslverr_q <= 1'b0;
      end
    end
  end

  // ==========================================================================
  // Software registers; reserved bits are masked on write
  always_ff @(posedge CLOCK or negedge ARST_N) begin
    if (!ARST_N) begin
      ctla_q  <= REG_RESET;
      ctlb_q  <= REG_RESET;
      chsel_q <= REG_RESET;
      didl_q  <= REG_RESET;
      didh_q  <= REG_RESET;
      misc_q  <= REG_RESET;
    end else if (wr_en) begin
      case (idx)
        IDX_CONTROL_A:      ctla_q  <= merge_byte(ctla_q, wbyte, CTLA_WMASK);
        IDX_CONTROL_B:      ctlb_q  <= merge_byte(ctlb_q, wbyte, CTLB_WMASK);
        IDX_CHANNEL_SELECT: chsel_q <= merge_byte(chsel_q, wbyte, CHSEL_WMASK);
        IDX_DID_LOW:        didl_q  <= wbyte;
        IDX_DID_HIGH:       didh_q  <= merge_byte(didh_q, wbyte, DIDH_WMASK);
        IDX_ANALOG_MISC:    misc_q  <= merge_byte(misc_q, wbyte, MISC_WMASK);
        default: begin
        end
      endcase
    end
  end

  // ==========================================================================
  // Result register and read lock
  logic conv_load;
  logic low_read;
  logic high_read;

  assign low_read  = rd_done && (idx == IDX_RESULT_LOW);
  assign high_read = rd_done && (idx == IDX_RESULT_HIGH);
  // A conversion that ends while locked is dropped, keeping both bytes coherent
  assign conv_load = CONV_IN.done && !lock_q;

  always_ff @(posedge CLOCK or negedge ARST_N) begin
    if (!ARST_N) begin
      result_q <= RESULT_RESET;
    end else if (conv_load) begin
      result_q <= format_result(ctlb_q[CTLB_BIPOLAR_BIT], CONV_IN.negative,
                                CONV_IN.magnitude);
    end
  end

  always_ff @(posedge CLOCK or negedge ARST_N) begin
    if (!ARST_N) begin
      lock_q <= 1'b0;
    end else if (high_read) begin
      lock_q <= 1'b0;
    end else if (low_read) begin
      lock_q <= 1'b1;
    end
  end

  // Set wins over either clear in the same cycle
  logic done_clear;

  assign done_clear = VECTOR_TAKEN ||
                      (wr_en && idx == IDX_CONTROL_A && wbyte[CTLA_DONE_BIT]);

  always_ff @(posedge CLOCK or negedge ARST_N) begin
    if (!ARST_N) begin
      done_q <= 1'b0;
    end else if (conv_load) begin
      done_q <= 1'b1;
    end else if (done_clear) begin
      done_q <= 1'b0;
    end
  end

  // ==========================================================================
  // Auto trigger
  logic [2:0] src;
  logic       auto_on;
  logic       trig_level;
  logic       to_free_run;

  assign src         = ctlb_q[CTLB_TRIG_LSB +: 3];
  assign auto_on     = ctla_q[CTLA_AUTO_BIT] && ctla_q[CTLA_ENABLE_BIT];
  assign to_free_run = (src == TRIG_FREE_RUN) && (src_prev_q != TRIG_FREE_RUN);

  always_comb begin
    case (adcrtc_trig_type'(src))
      TRIG_FREE_RUN: trig_level = done_q;
      default:       trig_level = TRIG_FLAGS[src];
    endcase
  end

  // Previous level follows the selected flag, so a source switch is an edge too
  always_ff @(posedge CLOCK or negedge ARST_N) begin
    if (!ARST_N) begin
      trig_prev_q <= 1'b0;
      src_prev_q  <= 3'h0;
      start_q     <= 1'b0;
    end else begin
      trig_prev_q <= trig_level;
      src_prev_q  <= src;
      start_q     <= auto_on && trig_level && !trig_prev_q && !to_free_run;
    end
  end

  // ==========================================================================
  // Pin input sampling; a change counts once stages two and three agree
  always_ff @(posedge CLOCK or negedge ARST_N) begin
    if (!ARST_N) begin
      sync1_q      <= '0;
      sync2_q      <= '0;
      sync3_q      <= '0;
      pin_stable_q <= '0;
      pin_value_q  <= '0;
    end else begin
      sync1_q <= PIN_RAW;
      sync2_q <= sync1_q;
      sync3_q <= sync2_q;
      for (int i = 0; i < NUM_PINS; i++) begin
        if (sync2_q[i] == sync3_q[i]) begin
          pin_stable_q[i] <= sync3_q[i];
        end
      end
      pin_value_q <= pin_stable_q & ~PIN_BUFFER_OFF;
    end
  end

  // ==========================================================================
  // Outputs
  assign APB_RSP.pready  = pready_q;
  assign APB_RSP.prdata  = prdata_q;
  assign APB_RSP.pslverr = pslverr_q;
  assign CONV_START      = start_q;
  assign CONV_ENABLE     = ctla_q[CTLA_ENABLE_BIT];
  assign BIPOLAR_MODE    = ctlb_q[CTLB_BIPOLAR_BIT];
  assign DONE_FLAG       = done_q;
  assign PIN_VALUE       = pin_value_q;
  assign PIN_BUFFER_OFF  = NUM_PINS'({didh_q[DIDH_LSB +: 3], didl_q});
  assign EXT_REF_SELECT  = misc_q[MISC_EXT_REF_BIT];
  assign REF_OUT_ENABLE  = misc_q[MISC_REF_OUT_BIT];
  assign ISRC_ENABLE     = misc_q[MISC_ISRC_BIT];

endmodule : adcrtc_top

// file: adcrtc_props.sv
// Port-level checks for the result and trigger control block.
// Assumes one clock domain; bound to every adcrtc_top instance.
`timescale 1ns/10ps
module adcrtc_props
  import adcrtc_pkg::*;
#(
  parameter int NUM_PINS = 11
) (
  // Clock and reset
  input wire logic                           CLOCK,
  input wire logic                           ARST_N,
  // Register bus
  input wire adcrtc_pkg::adcrtc_apb_req_type APB_REQ,
  input wire adcrtc_pkg::adcrtc_apb_rsp_type APB_RSP,
  // Core and outputs
  input wire adcrtc_pkg::adcrtc_conv_type    CONV_IN,
  input wire logic                           CONV_START,
  input wire logic                           CONV_ENABLE,
  input wire logic                           BIPOLAR_MODE,
  input wire logic                           DONE_FLAG,
  input wire logic [NUM_PINS-1:0]            PIN_VALUE,
  input wire logic [NUM_PINS-1:0]            PIN_BUFFER_OFF,
  input wire logic                           EXT_REF_SELECT,
  input wire logic                           REF_OUT_ENABLE
);
  logic       rd_acc;
  logic       wr_acc;
  logic [9:0] idx;
  assign idx    = APB_REQ.paddr[11:2];
  assign rd_acc = APB_REQ.psel & APB_REQ.penable & APB_RSP.pready & ~APB_REQ.pwrite;
  assign wr_acc = APB_REQ.psel & APB_REQ.penable & APB_RSP.pready & APB_REQ.pwrite & APB_REQ.pstrb[0]
                  & (APB_REQ.paddr[1:0] == 2'b00);
  default clocking @(posedge CLOCK); endclocking
  default disable iff (!ARST_N);
  // ==========================================================================
  // Checks
  property p_setup_answer;
    APB_REQ.psel && !APB_REQ.penable |=> APB_RSP.pready ##1 !APB_RSP.pready;
  endproperty
  a_setup_answer: assert property (p_setup_answer) else $error("bus answer not one cycle after setup");
  property p_start_pulse;
    CONV_START |=> !CONV_START;
  endproperty
  a_start_pulse: assert property (p_start_pulse) else $error("start request longer than one cycle");
  property p_start_enabled;
    CONV_START |-> $past(CONV_ENABLE);
  endproperty
  a_start_enabled: assert property (p_start_enabled) else $error("start while converter off");
  property p_done_cause;
    $rose(DONE_FLAG) |-> $past(CONV_IN.done);
  endproperty
  a_done_cause: assert property (p_done_cause) else $error("done flag set without conversion");
  // Value lags the mask by one edge, so only settled bits are judged
  property p_buf_zero;
    (PIN_VALUE & PIN_BUFFER_OFF & $past(PIN_BUFFER_OFF) & $past(PIN_BUFFER_OFF, 2)) == '0;
  endproperty
  a_buf_zero: assert property (p_buf_zero) else $error("disabled pin reads one");
  property p_ctlb_rsvd;
    rd_acc && idx == IDX_CONTROL_B |-> (APB_RSP.prdata & 32'hFFFF_FF08) == 32'h0000_0000;
  endproperty
  a_ctlb_rsvd: assert property (p_ctlb_rsvd) else $error("control B reserved bit set");
  property p_didh_rsvd;
    rd_acc && idx == IDX_DID_HIGH |-> (APB_RSP.prdata & 32'hFFFF_FF8F) == 32'h0000_0000;
  endproperty
  a_didh_rsvd: assert property (p_didh_rsvd) else $error("disable-high reserved bit set");
  property p_misc_rsvd;
    rd_acc && idx == IDX_ANALOG_MISC |-> (APB_RSP.prdata & 32'hFFFF_FFF8) == 32'h0000_0000;
  endproperty
  a_misc_rsvd: assert property (p_misc_rsvd) else $error("misc reserved bit set");
  property p_misc_out;
    wr_acc && idx == IDX_ANALOG_MISC |=> EXT_REF_SELECT == $past(APB_REQ.pwdata[2])
                                         && REF_OUT_ENABLE == $past(APB_REQ.pwdata[1]);
  endproperty
  a_misc_out: assert property (p_misc_out) else $error("reference enables not updated");
  property p_bipolar;
    wr_acc && idx == IDX_CONTROL_B |=> BIPOLAR_MODE == $past(APB_REQ.pwdata[7]);
  endproperty
  a_bipolar: assert property (p_bipolar) else $error("bipolar mode not updated");
endmodule : adcrtc_props
bind adcrtc_top adcrtc_props #(.NUM_PINS(NUM_PINS)) i_props (.CLOCK, .ARST_N, .APB_REQ, .APB_RSP, .CONV_IN,
  .CONV_START, .CONV_ENABLE, .BIPOLAR_MODE, .DONE_FLAG, .PIN_VALUE, .PIN_BUFFER_OFF, .EXT_REF_SELECT,
  .REF_OUT_ENABLE);

// file: adcrtc_top_tb.sv
// Self-checking bench for the result and trigger control block.
// Assumes adcrtc_pkg, adcrtc_top and adcrtc_props are compiled first.
`timescale 1ns/10ps
`define CHK(got, exp) begin samples_checked++; if ((got) !== (exp)) begin n_fail++; \
  $display("wrong value at %0t: got %h expected %h", $time, got, exp); end end
module adcrtc_top_tb;
  import adcrtc_pkg::*;
  localparam logic [9:0] MAP [8] = '{IDX_ANALOG_MISC, IDX_RESULT_LOW, IDX_RESULT_HIGH, IDX_CONTROL_A,
                                     IDX_CONTROL_B, IDX_CHANNEL_SELECT, IDX_DID_LOW, IDX_DID_HIGH};
  logic               clock = 1'b0;
  logic               arst_n;
  adcrtc_apb_req_type req;
  adcrtc_apb_rsp_type rsp;
  adcrtc_conv_type    conv;
  logic [7:1]         trig;
  logic               vector_taken, conv_start, conv_enable, bipolar_mode, done_flag;
  logic [10:0]        pin_raw, pin_value, pin_buffer_off;
  logic               ext_ref_select, ref_out_enable, isrc_enable;
  logic [31:0]        rd;
  logic               err;
  int                 n_fail, samples_checked, n_start;
  always #2.5 clock = ~clock;
  always @(posedge clock) if (conv_start === 1'b1) n_start <= n_start + 1;
  adcrtc_top #(.NUM_PINS(11)) i_dut (.CLOCK(clock), .ARST_N(arst_n), .APB_REQ(req), .APB_RSP(rsp),
    .CONV_IN(conv), .CONV_START(conv_start), .CONV_ENABLE(conv_enable), .BIPOLAR_MODE(bipolar_mode),
    .TRIG_FLAGS(trig), .VECTOR_TAKEN(vector_taken), .DONE_FLAG(done_flag), .PIN_RAW(pin_raw),
    .PIN_VALUE(pin_value), .PIN_BUFFER_OFF(pin_buffer_off), .EXT_REF_SELECT(ext_ref_select),
    .REF_OUT_ENABLE(ref_out_enable), .ISRC_ENABLE(isrc_enable));
  // ==========================================================================
  // Bus and stimulus tasks
  task automatic apb(input logic w, input logic [9:0] idx, input logic [7:0] d);
    int k;
    req <= '{psel: 1'b1, penable: 1'b0, pwrite: w, paddr: {idx, 2'b00}, pwdata: {24'h00_0000, d}, pstrb: 4'hF};
    @(posedge clock);
    req.penable <= 1'b1;
    k = 0;
    do begin @(posedge clock); k++; end while (rsp.pready !== 1'b1 && k < 16);
    if (rsp.pready !== 1'b1) begin n_fail++; test_done(); end
    rd = rsp.prdata;
    err = rsp.pslverr;
    req.psel <= 1'b0;
    req.penable <= 1'b0;
    // Idle edge keeps the next setup out of this time step
    @(posedge clock);
  endtask : apb
  task automatic wr(input logic [9:0] idx, input logic [7:0] d);
    apb(1'b1, idx, d);
  endtask : wr
  task automatic rdc(input logic [9:0] idx, input logic [7:0] exp);
    apb(1'b0, idx, 8'h00);
    `CHK(rd, {24'h00_0000, exp})
  endtask : rdc
  task automatic convert(input logic neg, input logic [9:0] mag);
    conv <= '{done: 1'b1, negative: neg, magnitude: mag};
    @(posedge clock);
    conv.done <= 1'b0;
    @(posedge clock);
  endtask : convert
  task automatic pulse(input int c, input int exp);
    n_start = 0;
    trig[c] <= 1'b1;
    repeat (4) @(posedge clock);
    trig[c] <= 1'b0;
    repeat (2) @(posedge clock);
    `CHK(n_start, exp)
  endtask : pulse
  // ==========================================================================
  // Scenarios
  task automatic t_reset_regs();
    for (int i = 0; i < 8; i++) rdc(MAP[i], 8'h00);
    apb(1'b0, 10'h076, 8'h00);
    `CHK({err, rd}, {1'b1, 32'h0000_0000})
  endtask : t_reset_regs
  task automatic t_regs();
    // Reserved bits are written as zero, as software must
    wr(IDX_CONTROL_B, 8'hF7);
    rdc(IDX_CONTROL_B, 8'hF7);
    `CHK(bipolar_mode, 1'b1)
    wr(IDX_DID_HIGH, 8'h70);
    rdc(IDX_DID_HIGH, 8'h70);
    wr(IDX_ANALOG_MISC, 8'h07);
    rdc(IDX_ANALOG_MISC, 8'h07);
    `CHK({ext_ref_select, ref_out_enable, isrc_enable}, 3'b111)
    wr(IDX_DID_LOW, 8'hFF);
    repeat (8) @(posedge clock);
    `CHK({pin_buffer_off, pin_value}, {11'h7FF, 11'h000})
    for (int i = 0; i < 8; i++) if (MAP[i] != IDX_RESULT_LOW && MAP[i] != IDX_RESULT_HIGH) wr(MAP[i], 8'h00);
    repeat (8) @(posedge clock);
    `CHK({pin_value, ext_ref_select, ref_out_enable}, {11'h5A5, 2'b00})
  endtask : t_regs
  task automatic t_format();
    convert(1'b0, 10'h2A5);
    `CHK(done_flag, 1'b1)
    rdc(IDX_RESULT_LOW, 8'hA5);
    rdc(IDX_RESULT_HIGH, 8'h02);
    wr(IDX_CHANNEL_SELECT, 8'h20);
    rdc(IDX_RESULT_LOW, 8'h40);
    rdc(IDX_RESULT_HIGH, 8'hA9);
    convert(1'b0, 10'h155);
    rdc(IDX_RESULT_HIGH, 8'h55);
    wr(IDX_CHANNEL_SELECT, 8'h00);
    convert(1'b1, 10'h012);
    rdc(IDX_RESULT_LOW, 8'hFF);
    rdc(IDX_RESULT_HIGH, 8'h03);
    wr(IDX_CONTROL_B, 8'h80);
    convert(1'b1, 10'h005);
    rdc(IDX_RESULT_LOW, 8'hFB);
    rdc(IDX_RESULT_HIGH, 8'h03);
    convert(1'b0, 10'h3F5);
    rdc(IDX_RESULT_LOW, 8'hF5);
    rdc(IDX_RESULT_HIGH, 8'h01);
    wr(IDX_CONTROL_B, 8'h00);
    wr(IDX_CONTROL_A, 8'h10);
    `CHK(done_flag, 1'b0)
    convert(1'b0, 10'h001);
    vector_taken <= 1'b1;
    @(posedge clock);
    vector_taken <= 1'b0;
    @(posedge clock);
    `CHK(done_flag, 1'b0)
  endtask : t_format
  task automatic t_lock();
    convert(1'b0, 10'h1C3);
    rdc(IDX_RESULT_LOW, 8'hC3);
    convert(1'b0, 10'h2DE);
    rdc(IDX_RESULT_HIGH, 8'h01);
    convert(1'b0, 10'h2DE);
    rdc(IDX_RESULT_LOW, 8'hDE);
    rdc(IDX_RESULT_HIGH, 8'h02);
  endtask : t_lock
  task automatic t_trigger();
    wr(IDX_CONTROL_A, 8'hB0);
    `CHK(conv_enable, 1'b1)
    rdc(IDX_CONTROL_A, 8'hA0);
    for (int c = 1; c < 8; c++) begin
      wr(IDX_CONTROL_B, 8'(c));
      pulse(c, 1);
    end
    trig[3] <= 1'b1;
    n_start = 0;
    wr(IDX_CONTROL_B, 8'h03);
    repeat (3) @(posedge clock);
    `CHK(n_start, 1)
    trig[3] <= 1'b0;
    convert(1'b0, 10'h0AA);
    n_start = 0;
    wr(IDX_CONTROL_B, 8'h00);
    repeat (3) @(posedge clock);
    `CHK(n_start, 0)
    wr(IDX_CONTROL_A, 8'hB0);
    convert(1'b0, 10'h0AB);
    repeat (3) @(posedge clock);
    `CHK(n_start, 1)
    wr(IDX_CONTROL_A, 8'h90);
    wr(IDX_CONTROL_B, 8'h01);
    pulse(1, 0);
    wr(IDX_CONTROL_A, 8'h20);
    `CHK(conv_enable, 1'b0)
    pulse(1, 0);
  endtask : t_trigger
  task automatic test_done();
    if (n_fail == 0 && samples_checked > 0) begin
      $display("Regression OK");
    end else begin
      $display("Regression broken");
    end
    $finish;
  endtask : test_done
  initial begin
    arst_n = 1'b0;
    req = '0;
    conv = '0;
    trig = '0;
    vector_taken = 1'b0;
    pin_raw = 11'h5A5;
    repeat (12) @(posedge clock);
    arst_n <= 1'b1;
    @(posedge clock);
    t_reset_regs();
    t_regs();
    t_format();
    t_lock();
    t_trigger();
    test_done();
  end
endmodule : adcrtc_top_tb
